// File: dv/manual_override_control_tb.sv
// bench for the override head: axi master, fieldbus stimulus, led timing
// assumes movr_top with a short ms tick and movr_tool at the magnet pin
module manual_override_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import movr_pkg::*;
  localparam int TC = 5; // cycles per ms, keeps holds short
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, ctrl_m;
  logic [2:0]  pos_fb_in, pos_fb_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, valve_cmd, mode_out;
  logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, magnet_in, bus_fail, maint_due, internal_fault, other_fault;
  logic        periph_fault, ext_sens_in, ext_sens_out, first_valve_output;
  logic        second_valve_output, led_fault, irq, ovr_m;
  int          errors, n_checks;
  movr_top #(.TICK_CYCLES(TC)) dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .magnet_in, .valve_cmd,
    .bus_fail, .maint_due, .internal_fault, .other_fault, .periph_fault, .mode_out,
    .pos_fb_in, .ext_sens_in, .pos_fb_out, .ext_sens_out, .first_valve_output,
    .second_valve_output, .led_fault, .irq);
  movr_tool tool (.clk, .magnet_in);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // verdict and end of run
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // random bus inputs, then outputs against the model
  task automatic cmp_out();
    logic wd;
    @(posedge clk);
    valve_cmd <= 2'($urandom);
    {pos_fb_in, ext_sens_in} <= 4'($urandom);
    repeat (3) @(posedge clk);
    wd = bus_fail & ctrl_m[CTRL_WD_EN];
    chk("valve1", !wd & (ovr_m | valve_cmd[0]), first_valve_output);
    chk("valve2", !wd & (ovr_m & ctrl_m[CTRL_DUAL] | valve_cmd[1]), second_valve_output);
    chk("periph", ovr_m, periph_fault);
    chk("mode", ovr_m ? MODE_OVR : MODE_NORMAL, mode_out);
    chk("posfb", {pos_fb_in, ext_sens_in}, {pos_fb_out, ext_sens_out});
  endtask
  // axi write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", RESP_OKAY, s_axi_bresp);
  endtask
  // axi read with expected data and answer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  // lit cycles over a window; a full period makes the phase irrelevant
  task automatic led(input int ms, input int on_ms);
    int n;
    n = 0;
    repeat (ms * TC) begin
      @(posedge clk);
      n += (led_fault === 1'b1);
    end
    n_checks++;
    if (n > on_ms * TC + 60 || n < on_ms * TC - 60) begin
      errors++;
      $display("[FAIL] led expected %0d seen %0d", on_ms * TC, n);
    end
  endtask
  // hang guard, a few thousand cycles past the ~95k-cycle run
  initial begin
    repeat (99000) @(posedge clk);
    errors++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(34));
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pos_fb_in, ext_sens_in} = '0;
    {valve_cmd, bus_fail, maint_due, internal_fault, other_fault} = '0;
    s_axi_wstrb = 4'hf;
    ovr_m = 1'b0;
    ctrl_m = CTRL_RST;
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    cmp_out();
    rd(REG_CTRL, 32'(CTRL_RST), RESP_OKAY);
    rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    tool.hold(500, TC);
    cmp_out();
    tool.hold(3000, TC);
    ovr_m = 1'b1;
    cmp_out();
    chk("irq", 1, irq);
    led(500, 50);
    internal_fault <= 1'b1;
    led(500, 450);
    internal_fault <= 1'b0;
    maint_due <= 1'b1;
    other_fault <= 1'b1;
    ctrl_m = 4'h7;
    wr(REG_CTRL, 32'(ctrl_m));
    led(500, 50);
    ctrl_m = 4'hb;
    wr(REG_CTRL, 32'(ctrl_m));
    cmp_out();
    bus_fail <= 1'b1;
    cmp_out();
    bus_fail <= 1'b0;
    other_fault <= 1'b0;
    tool.hold(3000, TC);
    ovr_m = 1'b0;
    cmp_out();
    wr(REG_IRQ_STAT, 32'h0000_000f);
    repeat (3) @(posedge clk);
    chk("irq", 0, irq);
    ctrl_m = 4'h2;
    wr(REG_CTRL, 32'(ctrl_m));
    tool.hold(3000, TC);
    // hold returns about 12 ms into the first flash
    led(800, 300 - 12);
    cmp_out();
    rd(REG_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
    chk("irq", 0, irq);
    ctrl_m = 4'h6;
    wr(REG_CTRL, 32'(ctrl_m));
    led(4000, 1000);
    ctrl_m = CTRL_RST;
    wr(REG_CTRL, 32'(ctrl_m));
    tool.hold(3000, TC);
    ovr_m = 1'b1;
    cmp_out();
    // power loss mid-override: override comes back cleared and registers at their reset values
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    ovr_m = 1'b0;
    cmp_out();
    rd(REG_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    summarize();
  end
endmodule

// File: dv/movr_tool.sv
// model of the magnetic service tool held against the head
// assumes the bench calls hold; the pin reads low with no magnet near
module movr_tool (
  // clock
  input  wire logic clk,
  // magnet pin, high while the tool is held
  output logic      magnet_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // no magnet at power-up
  initial magnet_in = 1'b0;
  // hold for ms at tck cycles each, small margin for the pin synchroniser
  task automatic hold(input int ms, input int tck);
    @(posedge clk);
    magnet_in <= 1'b1;
    repeat (ms * tck + 20) @(posedge clk);
    magnet_in <= 1'b0;
    // the head needs the release before the next toggle
    repeat (8 * tck) @(posedge clk);
  endtask
endmodule

// File: verilog/movr_blink.sv
// on/off blink generator stepped by a millisecond enable
// assumes restart is pulsed whenever the selected pattern changes
module movr_blink
  import movr_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // timing
  input  wire logic          ms_tick,
  input  wire logic          restart,
  input  wire logic [TW-1:0] on_ms,
  input  wire logic [TW-1:0] off_ms,
  // outputs
  output logic               led,
  output logic               period_end
);
  logic          off_r;   // 0 = on phase
  logic [TW-1:0] cnt_r;   // ms spent in phase

  wire [TW-1:0] cnt_inc  = cnt_r + 1'b1;
  wire [TW-1:0] ph_len   = off_r ? off_ms : on_ms;
  wire          ph_done  = ms_tick && (cnt_inc >= ph_len);

  // phase counter; a zero-length pattern simply never lights
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      off_r <= 1'b0;
      cnt_r <= '0;
    end else if (restart) begin
      off_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      if (ph_done) begin
        off_r <= ~off_r;
        cnt_r <= '0;
      end else if (ms_tick) begin
        cnt_r <= cnt_inc;
      end
    end
  end

  assign led        = !off_r && (on_ms != '0);
  // same-cycle end, so a counting parent can drop the pattern before a new on phase lights
  assign period_end = ph_done && off_r && !restart;
endmodule

// File: verilog/movr_pkg.sv
// constants, codes and pattern lookups for the magnet override block
// assumes a single 50 MHz clock and an active-low asynchronous reset
// What this block does
// (RL1) override forces first valve output on
// (RL2) override blinks fault colour 50/450 ms
// (RL3) disabled override: outputs unchanged, three 100ms flashes
// (RL4) operator holds magnet three seconds to toggle
// (RL5) reset clears override, normal operation resumes
// (RL6) override sets peripheral fault bit
// (RL7) override switches reported mode to override value
// (RL8) position feedback passes through unchanged
// (RL9) double-acting variant forces both valve outputs
// (RL10) watchdog on and bus failed: valves off
// (RL11) maintenance due and enabled: blink 1s/3s
// (RL12) override pattern below internal fault, above others
// (RL13) toggle only after continuous full hold time
package movr_pkg;
  // clock and the millisecond enable
  localparam int CLK_HZ      = 50_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TW          = 12;                  // width of a time in ms

  // times in milliseconds
  localparam logic [TW-1:0] HOLD_MS     = 12'd3000; // magnet hold time
  localparam logic [TW-1:0] OVR_ON_MS   = 12'd50;
  localparam logic [TW-1:0] OVR_OFF_MS  = 12'd450;
  localparam logic [TW-1:0] REJ_ON_MS   = 12'd100;
  localparam logic [TW-1:0] REJ_OFF_MS  = 12'd100;
  localparam logic [1:0]    REJ_FLASHES = 2'd3;
  localparam logic [TW-1:0] MNT_ON_MS   = 12'd1000;
  localparam logic [TW-1:0] MNT_OFF_MS  = 12'd3000;
  localparam logic [TW-1:0] INT_ON_MS   = 12'd450;
  localparam logic [TW-1:0] INT_OFF_MS  = 12'd50;
  localparam logic [TW-1:0] BUS_ON_MS   = 12'd250;
  localparam logic [TW-1:0] BUS_OFF_MS  = 12'd250;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

  // control fields and reset value
  localparam int         CTRL_W      = 4;
  localparam int         CTRL_OVR_EN = 0;
  localparam int         CTRL_WD_EN  = 1;
  localparam int         CTRL_MNT_EN = 2;
  localparam int         CTRL_DUAL   = 3;
  localparam logic [3:0] CTRL_RST    = 4'h3;

  // interrupt events
  localparam int         IRQ_W       = 4;
  localparam int         IRQ_OVR_ON  = 0;
  localparam int         IRQ_OVR_OFF = 1;
  localparam int         IRQ_REJ     = 2;
  localparam int         IRQ_BUSF    = 3;
  localparam logic [3:0] IRQ_RST     = 4'h0;

  // reported mode codes and bus answers
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_OVR    = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // override sequence, gray along the toggle path except the ST_OFF_WAIT to ST_IDLE step
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ARM_ON   = 3'h1,
    ST_ACT_WAIT = 3'h3,
    ST_ACTIVE   = 3'h2,
    ST_ARM_OFF  = 3'h6,
    ST_OFF_WAIT = 3'h7,
    ST_REJ_WAIT = 3'h5
  } movr_state_t;

  // led patterns, PAT_NONE first, then the rest in falling priority
  typedef enum logic [2:0] {
    PAT_NONE, PAT_INT, PAT_OVR, PAT_MNT, PAT_REJ, PAT_BUS
  } movr_pat_t;

  // on time of a pattern
  function automatic logic [TW-1:0] pat_on_ms(input movr_pat_t p);
    unique case (p)
      PAT_INT: pat_on_ms = INT_ON_MS;
      PAT_OVR: pat_on_ms = OVR_ON_MS;
      PAT_MNT: pat_on_ms = MNT_ON_MS;
      PAT_REJ: pat_on_ms = REJ_ON_MS;
      PAT_BUS: pat_on_ms = BUS_ON_MS;
      PAT_NONE: pat_on_ms = '0;
    endcase
  endfunction

  // off time of a pattern
  function automatic logic [TW-1:0] pat_off_ms(input movr_pat_t p);
    unique case (p)
      PAT_INT: pat_off_ms = INT_OFF_MS;
      PAT_OVR: pat_off_ms = OVR_OFF_MS;
      PAT_MNT: pat_off_ms = MNT_OFF_MS;
      PAT_REJ: pat_off_ms = REJ_OFF_MS;
      PAT_BUS: pat_off_ms = BUS_OFF_MS;
      PAT_NONE: pat_off_ms = '0;
    endcase
  endfunction
endpackage

// File: verilog/movr_sync.sv
// three-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk; output moves once stages 2 and 3 agree
module movr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // raw and filtered level
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;   // metastable stage, read only by s2
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  // per bit: adopt the level once two settled stages match
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        q_r[i]  <= 1'b0;
      end else begin
        s1_r[i] <= d[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign q = q_r;
endmodule

// File: verilog/movr_top.sv
// magnet override head: valve forcing, led patterns, fieldbus flags, registers
// assumes AXI4-Lite master on clk; fieldbus inputs are on clk, the magnet is a pin
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
module movr_top #(
  parameter int TICK_CYCLES = movr_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // axi4-lite write address and data
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // magnet sensor pin
  input  wire logic                  magnet_in,
  // fieldbus side
  input  wire logic [1:0]            valve_cmd,
  input  wire logic                  bus_fail,
  input  wire logic                  maint_due,
  input  wire logic                  internal_fault,
  input  wire logic                  other_fault,
  output logic                       periph_fault,
  output logic [1:0]                 mode_out,
  // position feedback
  input  wire logic [2:0]            pos_fb_in,
  input  wire logic                  ext_sens_in,
  output logic [2:0]                 pos_fb_out,
  output logic                       ext_sens_out,
  // valves, led, interrupt
  output logic                       first_valve_output,
  output logic                       second_valve_output,
  output logic                       led_fault,
  output logic                       irq
);
  import movr_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ---------------- millisecond enable ----------------
  logic [15:0] div_r;     // cycle divider
  logic        tick_r;    // one-cycle ms pulse
  wire         div_end = (div_r == 16'(TICK_CYCLES - 1));

  // divider wraps every ms
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_end ? '0 : div_r + 16'h0001;
      tick_r <= div_end;
    end
  end

  // ---------------- magnet input ----------------
  logic mag;              // filtered magnet level
  movr_sync #(.W(1)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (magnet_in),
    .q      (mag)
  );

  // ---------------- control registers ----------------
  logic [CTRL_W-1:0] ctrl_r;       // software configuration
  logic [IRQ_W-1:0]  irq_stat_r;   // sticky events
  logic [IRQ_W-1:0]  irq_mask_r;   // enables onto irq
  wire ovr_en  = ctrl_r[CTRL_OVR_EN];
  wire wd_en   = ctrl_r[CTRL_WD_EN];
  wire mnt_en  = ctrl_r[CTRL_MNT_EN];
  wire dual    = ctrl_r[CTRL_DUAL];

  // ---------------- override sequence ----------------
  movr_state_t   st_r;
  movr_state_t   st_nxt;
  logic [TW-1:0] hold_r;    // ms the magnet has been held
  wire arming    = (st_r == ST_ARM_ON) || (st_r == ST_ARM_OFF);
  wire hold_done = arming && mag && tick_r && (hold_r >= HOLD_MS - 12'd1); // RL4 RL13
  wire ovr_act   = (st_r == ST_ACT_WAIT) || (st_r == ST_ACTIVE) || (st_r == ST_ARM_OFF);
  wire ev_on     = (st_r == ST_ARM_ON) && hold_done && ovr_en;
  wire ev_rej    = (st_r == ST_ARM_ON) && hold_done && !ovr_en;   // RL3
  wire ev_off    = (st_r == ST_ARM_OFF) && hold_done;

  // next state; a release before the hold ends returns without effect
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:     if (mag) st_nxt = ST_ARM_ON;
      ST_ARM_ON: begin
        if (!mag) st_nxt = ST_IDLE;                      // RL13
        else if (ev_on) st_nxt = ST_ACT_WAIT;
        else if (ev_rej) st_nxt = ST_REJ_WAIT;           // RL3
      end
      ST_ACT_WAIT: if (!mag) st_nxt = ST_ACTIVE;
      ST_ACTIVE:   if (mag) st_nxt = ST_ARM_OFF;
      ST_ARM_OFF: begin
        if (!mag) st_nxt = ST_ACTIVE;                    // RL13
        else if (ev_off) st_nxt = ST_OFF_WAIT;
      end
      ST_OFF_WAIT: if (!mag) st_nxt = ST_IDLE;
      ST_REJ_WAIT: if (!mag) st_nxt = ST_IDLE;
      default:     st_nxt = ST_IDLE;
    endcase
  end

  // state and hold counter; reset leaves override off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r   <= ST_IDLE;                                 // RL5
      hold_r <= '0;
    end else begin
      st_r   <= st_nxt;
      hold_r <= (arming && mag) ? hold_r + {11'h000, tick_r} : '0;
    end
  end

  // ---------------- valve outputs and fieldbus flags ----------------
  logic       fv_r;
  logic       sv_r;
  logic       pf_r;
  logic [1:0] mode_r;
  logic [2:0] pos_r;
  logic       ext_r;
  wire        wd_trip = wd_en && bus_fail;
  // watchdog beats override: a dead bus parks the valves whenever wd_en is set
  wire        fv_nxt  = wd_trip ? 1'b0 : (ovr_act | valve_cmd[0]);         // RL1 RL10
  wire        sv_nxt  = wd_trip ? 1'b0 : ((ovr_act & dual) | valve_cmd[1]); // RL9 RL10

  // registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fv_r   <= 1'b0;
      sv_r   <= 1'b0;
      pf_r   <= 1'b0;
      mode_r <= MODE_NORMAL;
      pos_r  <= '0;
      ext_r  <= 1'b0;
    end else begin
      fv_r   <= fv_nxt;
      sv_r   <= sv_nxt;
      pf_r   <= ovr_act;                                 // RL6
      mode_r <= ovr_act ? MODE_OVR : MODE_NORMAL;        // RL7
      pos_r  <= pos_fb_in;                               // RL8
      ext_r  <= ext_sens_in;                             // RL8
    end
  end

  // ---------------- led pattern ----------------
  logic       rej_pend_r;   // reject flashes still owed
  logic [1:0] rej_cnt_r;
  movr_pat_t  pat_r;        // pattern now shown
  movr_pat_t  pat_sel;
  logic       blink_led;
  logic       blink_end;
  logic       led_r;

  // priority selection
  assign pat_sel = internal_fault      ? PAT_INT :       // RL12
                   ovr_act             ? PAT_OVR :       // RL2 RL12
                   (mnt_en && maint_due) ? PAT_MNT :     // RL11
                   rej_pend_r          ? PAT_REJ :       // RL3
                   (other_fault || bus_fail) ? PAT_BUS : PAT_NONE;

  movr_blink u_blink (
    .clk        (clk),
    .resetn     (resetn),
    .ms_tick    (tick_r),
    .restart    (pat_sel != pat_r),
    .on_ms      (pat_on_ms(pat_r)),
    .off_ms     (pat_off_ms(pat_r)),
    .led        (blink_led),
    .period_end (blink_end)
  );

  // pattern latch and reject flash count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pat_r      <= PAT_NONE;
      rej_pend_r <= 1'b0;
      rej_cnt_r  <= '0;
      led_r      <= 1'b0;
    end else begin
      pat_r <= pat_sel;
      led_r <= blink_led && (pat_sel == pat_r);
      if (ev_rej) begin
        rej_pend_r <= 1'b1;                              // RL3
        rej_cnt_r  <= '0;
      end else if (blink_end && pat_r == PAT_REJ) begin
        rej_cnt_r  <= rej_cnt_r + 2'd1;
        if (rej_cnt_r == REJ_FLASHES - 2'd1) begin
          rej_pend_r <= 1'b0;                            // RL3
        end
      end
    end
  end

  // ms the led has been lit, watched by the override pattern check
  logic [TW-1:0] lit_ms_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lit_ms_r <= '0;
    else lit_ms_r <= led_r ? lit_ms_r + {11'h000, tick_r} : '0;
  end

  // ---------------- axi4-lite slave ----------------
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        busf_d_r;
  logic        irq_r;

  wire aw_hs   = s_axi_awvalid && awready_r;
  wire w_hs    = s_axi_wvalid && wready_r;
  wire wr_go   = !awready_r && !wready_r && !bvalid_r;
  wire wr_ctrl = wr_go && (awaddr_r == REG_CTRL) && wstrb_r[0];
  wire wr_stat = wr_go && (awaddr_r == REG_IRQ_STAT) && wstrb_r[0];
  wire wr_mask = wr_go && (awaddr_r == REG_IRQ_MASK) && wstrb_r[0];
  wire wr_ok   = (awaddr_r == REG_CTRL) || (awaddr_r == REG_STATUS) ||
                 (awaddr_r == REG_IRQ_STAT) || (awaddr_r == REG_IRQ_MASK);
  wire ar_hs   = s_axi_arvalid && arready_r;

  // events and the read view of state
  wire [IRQ_W-1:0] ev_vec = {bus_fail && !busf_d_r, ev_rej, ev_off, ev_on};
  wire [IRQ_W-1:0] w1c    = wr_stat ? wdata_r[IRQ_W-1:0] : '0;
  wire [31:0] status_w = {25'h000_0000, led_r, mode_r, sv_r, fv_r, bus_fail, ovr_act};
  wire [31:0] rd_mux =
    (s_axi_araddr == REG_CTRL)     ? {28'h000_0000, ctrl_r} :
    (s_axi_araddr == REG_STATUS)   ? status_w :
    (s_axi_araddr == REG_IRQ_STAT) ? {28'h000_0000, irq_stat_r} :
    (s_axi_araddr == REG_IRQ_MASK) ? {28'h000_0000, irq_mask_r} : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS) ||
               (s_axi_araddr == REG_IRQ_STAT) || (s_axi_araddr == REG_IRQ_MASK);

  // write channel: hold address and data until both are in
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // config, sticky events (set beats clear), interrupt level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r     <= CTRL_RST;
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      busf_d_r   <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_r[CTRL_W-1:0];
      if (wr_mask) irq_mask_r <= wdata_r[IRQ_W-1:0];
      irq_stat_r <= (irq_stat_r & ~w1c) | ev_vec;
      busf_d_r   <= bus_fail;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------- outputs ----------------
  assign s_axi_awready       = awready_r;
  assign s_axi_wready        = wready_r;
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_arready       = arready_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rresp         = rresp_r;
  assign s_axi_rdata         = rdata_r;
  assign first_valve_output  = fv_r;
  assign second_valve_output = sv_r;
  assign periph_fault        = pf_r;
  assign mode_out            = mode_r;
  assign pos_fb_out          = pos_r;
  assign ext_sens_out        = ext_r;
  assign led_fault           = led_r;
  assign irq                 = irq_r;

  // ---------------- checks ----------------
  chk_valve_forced:  assert property (ovr_act && !wd_trip |=> fv_r) // RL1
    else $error("override did not force first valve");
  chk_overr_blink:   assert property (pat_r == PAT_OVR && led_r |-> lit_ms_r <= OVR_ON_MS) // RL2
    else $error("override pattern lit too long");
  chk_reject_keeps:  assert property (ev_rej |=> !ovr_act && rej_pend_r) // RL3
    else $error("disabled override changed state");
  chk_hold_brief:    assert property (st_r == ST_ARM_ON && !mag |=> st_r == ST_IDLE) // RL13
    else $error("short magnet contact not ignored");
  chk_reset_clear:   assert property ($rose(resetn) |-> !ovr_act) // RL5
    else $error("override survived reset");
  chk_fault_bit:     assert property (ovr_act |=> pf_r ##0 mode_r == MODE_OVR) // RL6
    else $error("fault bit or mode missing in override");
  chk_mode_normal:   assert property (!ovr_act |=> mode_r == MODE_NORMAL) // RL7
    else $error("mode not normal outside override");
  chk_feedback_pass: assert property (1'b1 |=> pos_r == $past(pos_fb_in)) // RL8
    else $error("feedback altered");
  chk_dual_force:    assert property (ovr_act && dual && !wd_trip |=> sv_r && fv_r) // RL9
    else $error("double-acting override not forcing both");
  chk_watchdog_off:  assert property (wd_trip |=> !fv_r && !sv_r) // RL10
    else $error("valves on after bus failure");
  chk_maint_pat:     assert property (mnt_en && maint_due && !ovr_act && !internal_fault // RL11
      |-> pat_sel == PAT_MNT)
    else $error("maintenance pattern not chosen");
  chk_pattern_prio:  assert property (ovr_act && !internal_fault |-> pat_sel == PAT_OVR) // RL12
    else $error("override pattern priority wrong");
  chk_hold_toggle:   assert property (ev_on |=> st_r == ST_ACT_WAIT) // RL4
    else $error("hold did not switch override on");
  cov_override_on:   cover property (ev_on);
  cov_override_off:  cover property (ev_off);
  cov_reject:        cover property (ev_rej ##[1:1000] rej_pend_r);
  cov_watchdog:      cover property (ovr_act && wd_trip);
endmodule
